// ### include/dolrc_pkg.sv
// Package for the DAC output latch and reference control block
package dolrc_pkg;

	// Reference source encodings (per channel)
	localparam logic [1:0] REF_SUPPLY     = 2'h0;
	localparam logic [1:0] REF_BANDGAP    = 2'h1;
	localparam logic [1:0] REF_EXT_UNBUF  = 2'h2;
	localparam logic [1:0] REF_EXT_BUF    = 2'h3;

	// Power-down encodings
	localparam logic [1:0] PD_NORMAL      = 2'h0;
	localparam logic [1:0] PD_PULL_1K     = 2'h1;
	localparam logic [1:0] PD_PULL_125K   = 2'h2;
	localparam logic [1:0] PD_OPEN        = 2'h3;

	localparam int NUM_CH        = 8;
	localparam int DATA_W_DEF    = 12;
	localparam int SPI_FRAME_W   = 24;
	localparam int ADDR_W        = 4;
	localparam int ADDR_LSB      = 16;
	localparam int WORD_W        = 16;

	// Command addresses
	localparam logic [3:0] ADDR_CFG_BASE = 4'h8;
	localparam logic [3:0] ADDR_NV_BASE  = 4'h0;

	// Frame opcode bits: bit 23 = nonvolatile, bit 22 = lock command
	localparam int OP_NV_BIT   = 23;
	localparam int OP_LOCK_BIT = 22;
	localparam int OP_SET_BIT  = 21;

	// Per-channel configuration carried as one unit
	typedef struct packed {
		logic [1:0] ref_sel;
		logic [1:0] pd_sel;
		logic       gain;
	} dolrc_cfg_t;

	localparam dolrc_cfg_t CFG_RESET = '{ref_sel: REF_SUPPLY, pd_sel: PD_NORMAL, gain: 1'b0};

	// Analog steering controls for one reference pin
	typedef struct packed {
		logic pin_as_input;
		logic pin_drive;
		logic pin_disconnect;
		logic buffered;
	} dolrc_refctl_t;

	// Analog steering for one output
	typedef struct packed {
		logic enable;
		logic double_gain;
		logic pull_1k;
		logic pull_125k;
	} dolrc_outctl_t;

endpackage

// ### src/dolrc_top.sv
// DAC output latch, reference routing and SPI command control
//
// What this block does
// - Strobe high: analog outputs held unchanged
// - Strobe low: pending values copied to outputs
// - Strobe low: writes reach outputs immediately
// - Strobe gates value, reference, powerdown, gain together
// - Nonvolatile programming only with high-voltage command
// - Chip select inactive: serial traffic ignored
// - Device is slave; host supplies serial clock
// - Reference 0 even channels, reference 1 odd
// - External selected: pin input; bandgap: pin driven
// - Supply reference: reference pin disconnected
// - External reference offers buffered and unbuffered modes
// - Gain unity or double for pin/bandgap
// - Powerdown: 1k, 125k pull-down, or open
// - Two update strobes, one per output group
// - DAC value width 8, 10 or 12 bits
// - Nonvolatile values restored at reset
// - Lock bits set only by high-voltage commands
// - Even strobe governs channels 0, 2, 4, 6
`timescale 1ns/1ns
module dolrc_top
	import dolrc_pkg::*;
#(
	parameter int DATA_W = DATA_W_DEF
) (
	input  wire logic                     clk_sys,
	input  wire logic                     rstn,
	input  wire logic                     spi_sck,
	input  wire logic                     spi_cs_n,
	input  wire logic                     spi_sdi,
	input  wire logic                     update_strobe_even,
	input  wire logic                     update_strobe_odd,
	input  wire logic                     high_voltage_command_pin,
	output logic [NUM_CH-1:0][DATA_W-1:0] out_value,
	output dolrc_cfg_t [NUM_CH-1:0]       out_cfg,
	output dolrc_outctl_t [NUM_CH-1:0]    analog_output,
	output dolrc_refctl_t                 reference_input_even,
	output dolrc_refctl_t                 reference_input_odd,
	output logic [NUM_CH-1:0]             lock_q,
	output logic                          cmd_done
);

	if (!(DATA_W == 8 || DATA_W == 10 || DATA_W == 12)) begin : g_bad_width
		$error("DATA_W must be 8, 10 or 12");
	end

	////////////////////////////////////////////////////////////////////////////////
	// SPI shift register, clocked by host sck only

	logic [SPI_FRAME_W-1:0] sh_q;
	logic [4:0]             bit_cnt_q;
	logic [SPI_FRAME_W-1:0] frame_q;
	logic                   frame_tgl_q;

	// System reset clears it too, else the first frame after power-up is lost
	wire logic spi_clr = spi_cs_n | ~rstn;

	// Counter cleared asynchronously by cs high, so a partial frame is lost
	always_ff @(posedge spi_sck or posedge spi_clr) begin
		if (spi_clr) begin
			bit_cnt_q <= 5'h00;
			sh_q      <= '0;
		end else begin
			sh_q <= {sh_q[SPI_FRAME_W-2:0], spi_sdi};
			if (bit_cnt_q == 5'(SPI_FRAME_W - 1)) begin
				bit_cnt_q <= 5'h00;
			end else begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
		end
	end

	// Complete frame captured and announced by a toggle
	always_ff @(posedge spi_sck or negedge rstn) begin
		if (!rstn) begin
			frame_q     <= '0;
			frame_tgl_q <= 1'b0;
		end else if (!spi_cs_n && bit_cnt_q == 5'(SPI_FRAME_W - 1)) begin
			frame_q     <= {sh_q[SPI_FRAME_W-2:0], spi_sdi};
			frame_tgl_q <= ~frame_tgl_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Crossings into clk_sys

	logic [2:0] tgl_sync_q;
	logic [2:0] even_sync_q;
	logic [2:0] odd_sync_q;
	logic [2:0] hv_sync_q;
	logic       even_lvl_q;
	logic       odd_lvl_q;
	logic       hv_lvl_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tgl_sync_q  <= 3'h0;
			even_sync_q <= 3'h7;
			odd_sync_q  <= 3'h7;
			hv_sync_q   <= 3'h0;
		end else begin
			tgl_sync_q  <= {tgl_sync_q[1:0], frame_tgl_q};
			even_sync_q <= {even_sync_q[1:0], update_strobe_even};
			odd_sync_q  <= {odd_sync_q[1:0], update_strobe_odd};
			hv_sync_q   <= {hv_sync_q[1:0], high_voltage_command_pin};
		end
	end

	// Level changes only once stages two and three agree
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			even_lvl_q <= 1'b1;
			odd_lvl_q  <= 1'b1;
			hv_lvl_q   <= 1'b0;
		end else begin
			if (even_sync_q[2] == even_sync_q[1]) even_lvl_q <= even_sync_q[2];
			if (odd_sync_q[2] == odd_sync_q[1])   odd_lvl_q  <= odd_sync_q[2];
			if (hv_sync_q[2] == hv_sync_q[1])     hv_lvl_q   <= hv_sync_q[2];
		end
	end

	// Frame word is stable for many clk_sys cycles after the toggle lands
	wire frame_evt = tgl_sync_q[2] ^ tgl_sync_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// Command decode

	wire logic [ADDR_W-1:0] cmd_addr = frame_q[ADDR_LSB +: ADDR_W];
	wire logic [WORD_W-1:0] cmd_data = frame_q[WORD_W-1:0];
	wire logic              is_nv    = frame_q[OP_NV_BIT];
	wire logic              is_lock  = frame_q[OP_LOCK_BIT];
	wire logic [2:0]        cmd_ch   = cmd_addr[2:0];
	wire logic              is_cfg   = cmd_addr[3];

	function automatic dolrc_cfg_t unpack_cfg(input logic [WORD_W-1:0] d);
		dolrc_cfg_t c;
		c.ref_sel = d[1:0];
		c.pd_sel  = d[3:2];
		c.gain    = d[4];
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Volatile, nonvolatile and lock storage

	logic [NUM_CH-1:0][DATA_W-1:0] vol_val_q;
	dolrc_cfg_t [NUM_CH-1:0]       vol_cfg_q;
	logic [NUM_CH-1:0][DATA_W-1:0] nv_val_q;
	dolrc_cfg_t [NUM_CH-1:0]       nv_cfg_q;
	logic                          restore_q;

	// Nonvolatile image survives rstn; it stands in for EEPROM
	always_ff @(posedge clk_sys) begin
		if (frame_evt && is_nv && !is_lock && hv_lvl_q && !lock_q[cmd_ch]) begin
			if (is_cfg) nv_cfg_q[cmd_ch] <= unpack_cfg(cmd_data);
			else        nv_val_q[cmd_ch] <= cmd_data[DATA_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lock_q <= '0;
		end else if (frame_evt && is_lock && hv_lvl_q) begin
			lock_q[cmd_ch] <= frame_q[OP_SET_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) restore_q <= 1'b1;
		else       restore_q <= 1'b0;
	end

	// First cycle after reset recalls the nonvolatile image
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			vol_val_q <= '0;
			vol_cfg_q <= {NUM_CH{CFG_RESET}};
		end else if (restore_q) begin
			vol_val_q <= nv_val_q;
			vol_cfg_q <= nv_cfg_q;
		end else if (frame_evt && !is_nv && !is_lock && !lock_q[cmd_ch]) begin
			if (is_cfg) vol_cfg_q[cmd_ch] <= unpack_cfg(cmd_data);
			else        vol_val_q[cmd_ch] <= cmd_data[DATA_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) cmd_done <= 1'b0;
		else       cmd_done <= frame_evt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output latches and analog steering

	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		// Even channels follow the even strobe
		wire logic strobe = (ch % 2 == 0) ? even_lvl_q : odd_lvl_q;

		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				out_value[ch] <= '0;
				out_cfg[ch]   <= CFG_RESET;
			end else if (!strobe) begin
				out_value[ch] <= vol_val_q[ch];
				out_cfg[ch]   <= vol_cfg_q[ch];
			end // Held otherwise
		end

		always_comb begin
			analog_output[ch].enable      = out_cfg[ch].pd_sel == PD_NORMAL;
			analog_output[ch].double_gain = out_cfg[ch].gain &&
				out_cfg[ch].ref_sel != REF_SUPPLY;
			analog_output[ch].pull_1k     = out_cfg[ch].pd_sel == PD_PULL_1K;
			analog_output[ch].pull_125k   = out_cfg[ch].pd_sel == PD_PULL_125K;
		end
	end

	function automatic dolrc_refctl_t ref_ctl(input logic [1:0] sel);
		dolrc_refctl_t r;
		r.pin_as_input   = sel == REF_EXT_UNBUF || sel == REF_EXT_BUF;
		r.pin_drive      = sel == REF_BANDGAP;
		r.pin_disconnect = sel == REF_SUPPLY;
		r.buffered       = sel == REF_EXT_BUF;
		return r;
	endfunction

	// Group reference follows channel 0 / channel 1 selection
	assign reference_input_even = ref_ctl(out_cfg[0].ref_sel);
	assign reference_input_odd  = ref_ctl(out_cfg[1].ref_sel);

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_even_high;
		even_lvl_q [*2];
	endsequence

	AST_HOLD_EVEN: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_even_high |-> $stable(out_value[0]) && $stable(out_cfg[0]))
		else $error("even output changed while strobe high");

	AST_HOLD_ODD: assert property (@(posedge clk_sys) disable iff (!rstn)
		odd_lvl_q && $past(odd_lvl_q) |-> $stable(out_value[1]))
		else $error("odd output changed while strobe high");

	AST_TRANSFER: assert property (@(posedge clk_sys) disable iff (!rstn)
		!even_lvl_q |=> out_value[2] == $past(vol_val_q[2]))
		else $error("even transfer missing");

	AST_CFG_TRANSFER: assert property (@(posedge clk_sys) disable iff (!rstn)
		!odd_lvl_q |=> out_cfg[3] == $past(vol_cfg_q[3]))
		else $error("config transfer missing");

	AST_IMMEDIATE: assert property (@(posedge clk_sys) disable iff (!rstn)
		!even_lvl_q && !restore_q && frame_evt && !is_nv && !is_lock && !is_cfg
		&& cmd_ch == 3'h0 && !lock_q[0] ##1 !even_lvl_q
		|=> out_value[0] == $past(cmd_data[DATA_W-1:0], 2))
		else $error("write not immediate with strobe low");

	AST_NV_GUARD: assert property (@(posedge clk_sys)
		frame_evt && is_nv && !hv_lvl_q |=> $stable(nv_val_q) && $stable(nv_cfg_q))
		else $error("nonvolatile written without high voltage");

	AST_LOCK_HV: assert property (@(posedge clk_sys) disable iff (!rstn)
		!hv_lvl_q |=> $stable(lock_q))
		else $error("lock changed without high voltage");

	AST_REF_PIN: assert property (@(posedge clk_sys) disable iff (!rstn)
		out_cfg[0].ref_sel == REF_BANDGAP |-> reference_input_even.pin_drive
		&& !reference_input_even.pin_as_input)
		else $error("bandgap reference pin not driven");

	AST_REF_SUPPLY: assert property (@(posedge clk_sys) disable iff (!rstn)
		out_cfg[1].ref_sel == REF_SUPPLY |-> reference_input_odd.pin_disconnect
		&& !analog_output[1].double_gain)
		else $error("supply reference pin not disconnected");

	AST_PD: assert property (@(posedge clk_sys) disable iff (!rstn)
		out_cfg[4].pd_sel == PD_PULL_125K |-> analog_output[4].pull_125k
		&& !analog_output[4].enable && !analog_output[4].pull_1k)
		else $error("powerdown termination wrong");

	AST_HOLD_EVEN6: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_even_high
		|-> $stable(out_value[6]) && $stable(out_cfg[6]))
		else $error("channel 6 changed while even strobe high");

	AST_HOLD_ODD7: assert property (@(posedge clk_sys) disable iff (!rstn)
		odd_lvl_q && $past(odd_lvl_q)
		|-> $stable(out_value[7]) && $stable(out_cfg[7]))
		else $error("channel 7 changed while odd strobe high");

	AST_EXT_BUF: assert property (@(posedge clk_sys) disable iff (!rstn)
		out_cfg[1].ref_sel == REF_EXT_BUF |-> reference_input_odd.buffered
		&& reference_input_odd.pin_as_input && !reference_input_odd.pin_drive)
		else $error("buffered external reference not set up");

	AST_GAIN2: assert property (@(posedge clk_sys) disable iff (!rstn)
		out_cfg[0].gain && out_cfg[0].ref_sel == REF_BANDGAP
		|-> analog_output[0].double_gain)
		else $error("double gain missing with bandgap reference");

	// Deselected traffic must leave the bit counter parked at zero
	AST_DESELECT: assert property (@(posedge spi_sck) disable iff (!rstn)
		spi_cs_n |-> bit_cnt_q == 5'h00)
		else $error("serial counter moved while deselected");

endmodule

// ### dv/dolrc_spi_host.sv
// Behavioural SPI host that drives frames into the latch control block
`timescale 1ns/1ns
module dolrc_spi_host (
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_sdi
);
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
	end

	// Clock stands still between frames; a deselected frame still toggles
	task automatic send(input logic [23:0] f, input int n, input logic sel);
		spi_cs_n = ~sel;
		#19;
		for (int i = 0; i < n; i++) begin
			spi_sdi = f[23-i];
			#32 spi_sck = 1'b1;
			#32 spi_sck = 1'b0;
		end
		#19;
		spi_cs_n = 1'b1;
		// Released line must not keep the last bit
		spi_sdi = ~spi_sdi;
	endtask
endmodule

// ### dv/dolrc_top_bench.sv
// Self-checking bench for the DAC output latch and reference control block
`timescale 1ns/1ns
module dolrc_top_bench;
	import dolrc_pkg::*;
	logic                        clk_sys, rstn, sck, cs_n, sdi, str_e, str_o, hv, cmd_done;
	logic [NUM_CH-1:0][11:0]     out_value;
	dolrc_cfg_t [NUM_CH-1:0]     out_cfg;
	dolrc_outctl_t [NUM_CH-1:0]  aout;
	dolrc_refctl_t               ref_e, ref_o;
	logic [NUM_CH-1:0]           lock_q;
	logic [3:0]                  pd_exp [4] = '{4'h8, 4'h2, 4'h1, 4'h0};
	logic [3:0]                  ref_exp [4] = '{4'h2, 4'h4, 4'h8, 4'h9};
	int                          fails = 0;
	int                          checks_done = 0;

	dolrc_top #(.DATA_W(12)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .spi_sck(sck),
		.spi_cs_n(cs_n), .spi_sdi(sdi), .update_strobe_even(str_e),
		.update_strobe_odd(str_o), .high_voltage_command_pin(hv), .out_value(out_value),
		.out_cfg(out_cfg), .analog_output(aout), .reference_input_even(ref_e),
		.reference_input_odd(ref_o), .lock_q(lock_q), .cmd_done(cmd_done));
	dolrc_spi_host host_u (.spi_sck(sck), .spi_cs_n(cs_n), .spi_sdi(sdi));

	always #50 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	function automatic logic [23:0] mk(input logic [2:0] op, input logic [3:0] a,
		input logic [15:0] d);
		return {op, 1'b0, a, d};
	endfunction

	// Pins pass a 4 cycle synchroniser, so allow 8 cycles to settle
	task automatic pins(input logic e, input logic o, input logic h);
		str_e = e;
		str_o = o;
		hv = h;
		cycles(8);
	endtask

	// exp: 1 pulse required, 0 none allowed, -1 not judged
	task automatic xfer(input logic [23:0] f, input int n, input logic sel, input int exp);
		logic seen;
		seen = 1'b0;
		host_u.send(f, n, sel);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_sys);
			if (cmd_done === 1'b1) begin
				seen = 1'b1;
			end
		end
		#1;
		if (exp >= 0) begin
			check("cmd_done", 12'(seen), 12'(exp));
		end
		if (exp == 1 && seen !== 1'b1) begin
			test_done();
		end
	endtask

	task automatic do_reset();
		cycles(1);
		rstn = 1'b0;
		cycles(6);
		rstn = 1'b1;
		cycles(2);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		// Start released so the first reset is a real falling edge
		rstn = 1'b1;
		str_e = 1'b1;
		str_o = 1'b1;
		hv = 1'b0;
		do_reset();
		// Known nonvolatile image first; every channel recalls into 125k power-down
		pins(1'b1, 1'b1, 1'b1);
		for (int c = 0; c < NUM_CH; c++) begin
			xfer(mk(3'h4, {1'b0, 3'(c)}, 16'h0100 + 16'(c)), 24, 1'b1, 1);
			xfer(mk(3'h4, {1'b1, 3'(c)}, 16'h0008), 24, 1'b1, 1);
		end
		pins(1'b1, 1'b1, 1'b0);
		do_reset();
		xfer(mk(3'h0, 4'h0, 16'h0abc), 24, 1'b1, 1);
		xfer(mk(3'h0, 4'h1, 16'h0123), 24, 1'b1, 1);
		xfer(mk(3'h0, 4'h8, 16'h0011), 24, 1'b1, 1);
		check("out_value0", out_value[0], 12'h000);
		check("out_cfg0", 12'(out_cfg[0]), 12'h000);
		pins(1'b0, 1'b1, 1'b0);
		check("out_value0", out_value[0], 12'habc);
		check("out_cfg0", 12'(out_cfg[0]), 12'h009);
		check("out_value1", out_value[1], 12'h000);
		check("out_value6", out_value[6], 12'h106);
		check("out_ctl4", 12'(aout[4]), 12'h001);
		check("ref_even", 12'(ref_e), 12'h004);
		xfer(mk(3'h0, 4'h2, 16'h05a5), 24, 1'b1, 1);
		check("out_value2", out_value[2], 12'h5a5);
		pins(1'b0, 1'b0, 1'b0);
		xfer(mk(3'h0, 4'h9, 16'h0003), 24, 1'b1, 1);
		check("out_value1", out_value[1], 12'h123);
		check("ref_odd", 12'(ref_o), 12'h009);
		xfer(mk(3'h0, 4'h0, 16'h0777), 24, 1'b1, 1);
		check("out_value0", out_value[0], 12'h777);
		for (int p = 0; p < 4; p++) begin
			xfer(mk(3'h0, 4'h8, {11'h0, 1'b0, 2'(p), REF_BANDGAP}), 24, 1'b1, 1);
			check("out_ctl0", 12'(aout[0]), 12'(pd_exp[p]));
		end
		for (int r = 0; r < 4; r++) begin
			xfer(mk(3'h0, 4'h8, {11'h0, 1'b1, PD_NORMAL, 2'(r)}), 24, 1'b1, 1);
			check("ref_even", 12'(ref_e), 12'(ref_exp[r]));
			check("out_ctl0", 12'(aout[0]), (r == 0) ? 12'h008 : 12'h00c);
		end
		xfer(mk(3'h0, 4'h2, 16'h0111), 10, 1'b1, 0);
		check("out_value2", out_value[2], 12'h5a5);
		xfer(mk(3'h0, 4'h2, 16'h0222), 24, 1'b0, 0);
		check("out_value2", out_value[2], 12'h5a5);
		pins(1'b1, 1'b0, 1'b0);
		xfer(mk(3'h0, 4'h2, 16'h0333), 24, 1'b1, 1);
		check("out_value2", out_value[2], 12'h5a5);
		// Nonvolatile image survives reset; only the high-voltage write counts
		pins(1'b1, 1'b0, 1'b1);
		xfer(mk(3'h4, 4'h3, 16'h03c3), 24, 1'b1, -1);
		pins(1'b1, 1'b0, 1'b0);
		xfer(mk(3'h4, 4'h3, 16'h0111), 24, 1'b1, -1);
		xfer(mk(3'h0, 4'h4, 16'h00aa), 24, 1'b1, 1);
		xfer(mk(3'h3, 4'h4, 16'h0000), 24, 1'b1, -1);
		check("lock4", 12'(lock_q[4]), 12'h000);
		pins(1'b1, 1'b0, 1'b1);
		xfer(mk(3'h3, 4'h4, 16'h0000), 24, 1'b1, -1);
		check("lock4", 12'(lock_q[4]), 12'h001);
		pins(1'b0, 1'b0, 1'b0);
		xfer(mk(3'h0, 4'h4, 16'h0444), 24, 1'b1, -1);
		check("out_value4", out_value[4], 12'h0aa);
		do_reset();
		pins(1'b1, 1'b0, 1'b0);
		check("out_value3", out_value[3], 12'h3c3);
		test_done();
	end
endmodule
